/* bench/ocd_props.sv */
`include "clkdiv_defines.svh"

module ocd_props (
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  RESET_N,
  // Register bus
  input wire clkdiv_pkg::bus_addr_t ADDRESS,
  input wire logic                  READ,
  input wire logic                  WRITE,
  input wire clkdiv_pkg::bus_word_t WRITEDATA,
  input wire logic [3:0]            BYTEENABLE,
  input wire clkdiv_pkg::bus_word_t READDATA,
  input wire logic                  WAITREQUEST,
  // Sources and outputs
  input wire logic                  VCO_IN,
  input wire logic                  EXT_CLK_IN,
  input wire logic                  CHIP_SYNC_N,
  input wire logic                  SECOND_PAIR_OUTPUT_A,
  input wire logic                  SECOND_PAIR_OUTPUT_B,
  input wire logic                  LOWSWING_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  import clkdiv_pkg::*;
  reg_byte_t d2_r;
  reg_byte_t rt_r;
  reg_byte_t ls_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Shadows let the held-level checks know the programmed mode
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      d2_r <= `RST_DIV2_CTRL;
      rt_r <= `RST_ROUTE_DUTY;
      ls_r <= `RST_LS_CTRL;
    end else if (WRITE && !WAITREQUEST && BYTEENABLE[0]) begin
      case (ADDRESS[11:2])
        `IDX_DIV2_CTRL:  d2_r <= WRITEDATA[7:0];
        `IDX_ROUTE_DUTY: rt_r <= WRITEDATA[7:0];
        `IDX_LS_CTRL:    ls_r <= WRITEDATA[7:0];
        default: ;
      endcase
    end
  end
  // Six quiet cycles cover synchroniser, output flop and cascade lag
  sequence s_held;
    (!CHIP_SYNC_N && !WRITE) [*6];
  endsequence
  property p_pair_compl;
    SECOND_PAIR_OUTPUT_B == !SECOND_PAIR_OUTPUT_A;
  endproperty
  a_pair_compl: assert property (p_pair_compl) else $error("pair not complementary");
  property p_wait_one;
    !WAITREQUEST |=> WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_answer;
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in one cycle");
  property p_pair_held;
    s_held ##0 (!d2_r[6] && !d2_r[7] && !rt_r[1]) |-> SECOND_PAIR_OUTPUT_A == d2_r[4];
  endproperty
  a_pair_held: assert property (p_pair_held) else $error("pair not at start level");
  property p_pair_force;
    s_held ##0 (d2_r[6] && !d2_r[7] && !rt_r[1]) |-> SECOND_PAIR_OUTPUT_A == d2_r[5];
  endproperty
  a_pair_force: assert property (p_pair_force) else $error("pair not forced");
  property p_ls_held;
    s_held ##0 (!ls_r[3] && !ls_r[5]) |-> LOWSWING_OUT == ls_r[1];
  endproperty
  a_ls_held: assert property (p_ls_held) else $error("low-swing not held");
  property p_ls_force;
    s_held ##0 (ls_r[3] && !ls_r[5]) |-> LOWSWING_OUT == ls_r[2];
  endproperty
  a_ls_force: assert property (p_ls_force) else $error("low-swing not forced");
  property p_sync_release;
    $rose(CHIP_SYNC_N) && !d2_r[6] && !d2_r[7] && !rt_r[1] && !d2_r[4]
      |-> ##2 !SECOND_PAIR_OUTPUT_A;
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("early edge");
  c_release: cover property ($rose(CHIP_SYNC_N));
  c_read: cover property (READ && !WAITREQUEST);
  c_ls_rise: cover property ($rose(LOWSWING_OUT));
endmodule

/* bench/tb_top.sv */
`include "clkdiv_defines.svh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import clkdiv_pkg::*;
  logic       CLK = 1'b0;
  logic       RESET_N = 1'b0;
  bus_addr_t  ADDRESS = 12'h000;
  logic       READ = 1'b0;
  logic       WRITE = 1'b0;
  bus_word_t  WRITEDATA = 32'h0;
  logic [3:0] BYTEENABLE = 4'h0;
  bus_word_t  READDATA;
  logic       WAITREQUEST;
  logic       VCO_IN = 1'b0;
  logic       EXT_CLK_IN = 1'b0;
  logic       CHIP_SYNC_N = 1'b1;
  logic       SECOND_PAIR_OUTPUT_A;
  logic       SECOND_PAIR_OUTPUT_B;
  logic       LOWSWING_OUT;
  int         failures = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         ecnt = 0;
  logic [2:0] vcnt = 3'h0;

  output_channel_clock_dividers uut (
    .CLK(CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .VCO_IN(VCO_IN), .EXT_CLK_IN(EXT_CLK_IN),
    .CHIP_SYNC_N(CHIP_SYNC_N), .SECOND_PAIR_OUTPUT_A(SECOND_PAIR_OUTPUT_A),
    .SECOND_PAIR_OUTPUT_B(SECOND_PAIR_OUTPUT_B), .LOWSWING_OUT(LOWSWING_OUT));

  always #2 CLK = ~CLK;

  // Sources hold each level several CLK so the synchronisers never miss one
  always @(posedge CLK) begin
    vcnt <= vcnt + 3'h1;
    VCO_IN <= vcnt[2];
    ecnt <= (ecnt == 11) ? 0 : ecnt + 1;
    EXT_CLK_IN <= (ecnt < 6);
  end

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [9:0] idx, input reg_byte_t wd,
                     input logic [3:0] be, output reg_byte_t rd);
    @(posedge CLK);
    ADDRESS    <= {idx, 2'h0};
    WRITE      <= wr;
    READ       <= !wr;
    WRITEDATA  <= {24'h000000, wd};
    BYTEENABLE <= be;
    do begin
      @(posedge CLK);
    end while (WAITREQUEST !== 1'b0);
    rd = READDATA[7:0];
    READ  <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input reg_byte_t d);
    reg_byte_t x;
    bus(1'b1, idx, d, 4'h1, x);
  endtask

  function automatic logic sig(input logic ls);
    return ls ? LOWSWING_OUT : SECOND_PAIR_OUTPUT_A;
  endfunction

  task automatic edge_wait(input logic ls, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (sig(ls) !== lvl && n < 500);
  endtask

  // First period after a change may be partial, so the second is judged
  task automatic widths(input logic ls, input int hi, input int lo);
    int a;
    int h;
    int l;
    repeat (2) begin
      edge_wait(ls, 1'b0, a);
      edge_wait(ls, 1'b1, a);
      edge_wait(ls, 1'b0, h);
      edge_wait(ls, 1'b1, l);
    end
    `CHK(h, hi)
    `CHK(l, lo)
  endtask

  task automatic t_regs;
    logic [9:0] idx[8] = '{`IDX_DIV2_TIMING, `IDX_DIV2_CTRL, `IDX_ROUTE_DUTY,
      `IDX_LS1_TIMING, `IDX_LS_PHASE, `IDX_LS2_TIMING, `IDX_LS_CTRL, `IDX_INPUT_SEL};
    reg_byte_t rst[8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
    reg_byte_t d;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, idx[i], 8'h00, 4'h1, d);
      `CHK(d, rst[i])
    end
    for (int i = 0; i < 7; i++) begin
      wr(idx[i], 8'hA5);
      bus(1'b0, idx[i], 8'h00, 4'h1, d);
      `CHK(d, 8'hA5)
    end
    bus(1'b1, `IDX_LS_PHASE, 8'h3C, 4'h0, d);
    bus(1'b0, `IDX_LS_PHASE, 8'h00, 4'h1, d);
    `CHK(d, 8'hA5)
    wr(10'h000, 8'hFF);
    bus(1'b0, 10'h000, 8'h00, 4'h1, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 7; i++) wr(idx[i], rst[i]);
  endtask

  task automatic t_lowswing;
    wr(`IDX_LS2_TIMING, 8'h10);
    widths(1'b1, 16, 32);
    wr(`IDX_LS2_TIMING, 8'h20);
    wr(`IDX_LS_CTRL, 8'h10);
    widths(1'b1, 8, 24);
    wr(`IDX_LS1_TIMING, 8'h12);
    wr(`IDX_LS_CTRL, 8'h20);
    widths(1'b1, 24, 16);
  endtask

  task automatic t_pair;
    widths(1'b0, 4, 4);
    wr(`IDX_DIV2_TIMING, 8'h20);
    wr(`IDX_DIV2_CTRL, 8'h00);
    wr(`IDX_ROUTE_DUTY, 8'h01);
    widths(1'b0, 8, 24);
    wr(`IDX_ROUTE_DUTY, 8'h00);
    widths(1'b0, 16, 16);
    wr(`IDX_ROUTE_DUTY, 8'h02);
    wr(`IDX_INPUT_SEL, 8'h00);
    widths(1'b0, 6, 6);
    wr(`IDX_INPUT_SEL, 8'h01);
    widths(1'b0, 16, 16);
    wr(`IDX_INPUT_SEL, 8'h02);
    widths(1'b0, 4, 4);
  endtask

  // Release is aligned to the same source phase so only the offset differs
  // Low-swing still has stage 2 bypassed and stage 1 at low 2, high 3
  task automatic t_sync;
    int t[2];
    int u[2];
    wr(`IDX_ROUTE_DUTY, 8'h01);
    wr(`IDX_DIV2_TIMING, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(`IDX_DIV2_CTRL, (p == 1) ? 8'h03 : 8'h00);
      wr(`IDX_LS_PHASE, (p == 1) ? 8'h02 : 8'h00);
      CHIP_SYNC_N <= 1'b0;
      repeat (12) @(posedge CLK);
      `CHK(SECOND_PAIR_OUTPUT_A, 1'b0)
      `CHK(LOWSWING_OUT, 1'b0)
      while (vcnt != 3'h0) @(posedge CLK);
      CHIP_SYNC_N <= 1'b1;
      t[p] = 0;
      u[p] = 0;
      for (int n = 1; n < 200 && (t[p] == 0 || u[p] == 0); n++) begin
        @(posedge CLK);
        if (t[p] == 0 && SECOND_PAIR_OUTPUT_A === 1'b1) t[p] = n;
        if (u[p] == 0 && LOWSWING_OUT === 1'b1) u[p] = n;
      end
    end
    `CHK(t[1] - t[0], 24)
    `CHK(u[1] - u[0], 16)
  endtask

  task automatic hold_chk(input logic [9:0] idx, input reg_byte_t v, input logic ls,
                          input logic exp);
    wr(idx, v);
    repeat (10) @(posedge CLK);
    `CHK(sig(ls), exp)
  endtask

  task automatic t_hold;
    CHIP_SYNC_N <= 1'b0;
    hold_chk(`IDX_DIV2_CTRL, 8'h10, 1'b0, 1'b1);
    hold_chk(`IDX_DIV2_CTRL, 8'h60, 1'b0, 1'b1);
    hold_chk(`IDX_DIV2_CTRL, 8'h40, 1'b0, 1'b0);
    hold_chk(`IDX_LS_CTRL, 8'h0C, 1'b1, 1'b1);
    hold_chk(`IDX_LS_CTRL, 8'h08, 1'b1, 1'b0);
    hold_chk(`IDX_LS_CTRL, 8'h02, 1'b1, 1'b1);
    hold_chk(`IDX_LS_CTRL, 8'h00, 1'b1, 1'b0);
    CHIP_SYNC_N <= 1'b1;
  endtask

  initial begin
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    t_regs;
    t_lowswing;
    t_pair;
    t_sync;
    t_hold;
    tally_and_finish;
  end
endmodule

bind output_channel_clock_dividers ocd_props u_props (
  .CLK(CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .VCO_IN(VCO_IN), .EXT_CLK_IN(EXT_CLK_IN),
  .CHIP_SYNC_N(CHIP_SYNC_N), .SECOND_PAIR_OUTPUT_A(SECOND_PAIR_OUTPUT_A),
  .SECOND_PAIR_OUTPUT_B(SECOND_PAIR_OUTPUT_B), .LOWSWING_OUT(LOWSWING_OUT));

/* hdl/chan_divider.sv */
module chan_divider #(
  parameter int CW = 4
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Divider input
  input  wire logic          in_rise,
  input  wire logic          in_level,
  // Control
  input  wire logic          hold,
  input  wire logic          bypass,
  input  wire logic          start_high,
  input  wire logic [CW-1:0] low_cycles,
  input  wire logic [CW-1:0] high_cycles,
  input  wire logic [CW-1:0] phase,
  // Output
  output logic               div_out
);

  logic          level_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] delay_r;

  // Counters freeze under bypass unless hold reloads them, standing in for the powered-down divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 1'b0;
      cnt_r   <= '0;
      delay_r <= '0;
    end else if (hold) begin
      level_r <= start_high;
      cnt_r   <= '0;
      delay_r <= phase;
    end else if (in_rise && !bypass) begin
      if (delay_r != '0) begin
        delay_r <= delay_r - CW'(1);
      end else if (cnt_r == (level_r ? high_cycles : low_cycles)) begin
        level_r <= ~level_r;
        cnt_r   <= '0;
      end else begin
        cnt_r   <= cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_out <= 1'b0;
    end else begin
      div_out <= bypass ? in_level : level_r;
    end
  end

endmodule

/* hdl/output_channel_clock_dividers.sv */
// How it works
// - With sync ignored and sync held, second pair output follows force bit 5, unless the direct-route bit sends VCO or external clock.
// - Bit 4 picks the level the second pair divider starts at, low by default.
// - Bits [3:0] hold the second pair divider phase offset, reset zero.
// - Direct-route bit sends VCO (sel 10b) or external clock (00b) to the pair.
// - Bit 0 clear keeps duty correction on; set turns it off.
// - First low-swing stage stays low for bits [7:4] plus one input cycles.
// - First low-swing stage stays high for bits [3:0] plus one input cycles.
// - Second low-swing stage timing comes from its own register, fields plus one.
// - One register holds both low-swing phase offsets, second high nibble.
// - Bypass bit 5 passes the second low-swing stage input straight through.
// - Bypass bit 4 passes the first low-swing stage input straight through.
// - Low-swing divider obeys chip sync unless sync-ignore bit 3 is set.
// - Force bit 2 sets low-swing output level while chip sync is held; needs sync-ignore set by software.
// - Second pair divider low and high times are fields [7:4],[3:0] plus one when duty bit 0 is set.
// - Bypass bit 7, set at reset, routes second pair divider input to output.
// - Second pair divider obeys chip sync unless sync-ignore bit 6 is set.
`include "clkdiv_defines.svh"

module output_channel_clock_dividers (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  // Avalon-MM slave
  input  wire clkdiv_pkg::bus_addr_t ADDRESS,
  input  wire logic                 READ,
  input  wire logic                 WRITE,
  input  wire clkdiv_pkg::bus_word_t WRITEDATA,
  input  wire logic [3:0]           BYTEENABLE,
  output clkdiv_pkg::bus_word_t     READDATA,
  output logic                      WAITREQUEST,
  // Clock sources and chip sync
  input  wire logic                 VCO_IN,
  input  wire logic                 EXT_CLK_IN,
  input  wire logic                 CHIP_SYNC_N,
  // Channel outputs
  output logic                      SECOND_PAIR_OUTPUT_A,
  output logic                      SECOND_PAIR_OUTPUT_B,
  output logic                      LOWSWING_OUT
);

  import clkdiv_pkg::*;

  function automatic logic reg_hit(input bus_addr_t addr, input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx);
  endfunction

  // Splits the programmed period into near-equal halves, period unchanged
  function automatic logic [7:0] balance(input logic [3:0] low_c, input logic [3:0] high_c);
    logic [4:0] total;
    logic [4:0] hi_len;
    logic [4:0] lo_len;
    total  = 5'({1'b0, low_c}) + 5'({1'b0, high_c}) + 5'h02;
    hi_len = total >> 1;
    lo_len = total - hi_len;
    balance = {4'(lo_len - 5'h01), 4'(hi_len - 5'h01)};
  endfunction

  bus_state_t  state_r;
  logic        wait_r;
  bus_word_t   rdata_r;
  bus_word_t   rdata_nxt;
  logic        wr_en;
  reg_byte_t   second_pair_divider_timing_r;
  reg_byte_t   second_pair_divider_control_r;
  reg_byte_t   second_pair_route_and_duty_r;
  reg_byte_t   lowswing_first_stage_timing_r;
  reg_byte_t   lowswing_phase_offsets_r;
  reg_byte_t   lowswing_second_stage_timing_r;
  reg_byte_t   lowswing_bypass_and_sync_r;
  input_sel_t  input_sel_r;
  logic [2:0]  pins_s;
  logic        vco_s;
  logic        ext_s;
  logic        sync_active;
  logic        src_level;
  logic        src_prev_r;
  logic        src_rise;
  logic        div2_nosync;
  logic        div2_hold;
  logic        div2_force;
  logic [7:0]  div2_times;
  logic        div2_out;
  logic        pair_nxt;
  logic        ls_nosync;
  logic        ls_hold;
  logic        ls_force;
  logic        ls1_out;
  logic        ls1_prev_r;
  logic        ls1_rise;
  logic        ls2_out;

  // Pin synchroniser, bus and register file
  sync_2ff #(.W (3)) u_pin_sync (
    .clk      (CLK),
    .rst_n    (RESET_N),
    .async_in ({CHIP_SYNC_N, EXT_CLK_IN, VCO_IN}),
    .sync_out (pins_s)
  );

  // Every access costs a wait state so read data come from a register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= BUS_IDLE;
      wait_r  <= 1'b1;
    end else begin
      unique case (state_r)
        BUS_IDLE: begin
          if (READ || WRITE) begin
            state_r <= BUS_ACK;
            wait_r  <= 1'b0;
          end
        end
        BUS_ACK: begin
          state_r <= BUS_IDLE;
          wait_r  <= 1'b1;
        end
      endcase
    end
  end

  assign WAITREQUEST = wait_r;
  assign wr_en       = (state_r == BUS_ACK) && WRITE && BYTEENABLE[0];

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_hit(ADDRESS, `IDX_DIV2_TIMING)) begin
      rdata_nxt[7:0] = second_pair_divider_timing_r;
    end else if (reg_hit(ADDRESS, `IDX_DIV2_CTRL)) begin
      rdata_nxt[7:0] = second_pair_divider_control_r;
    end else if (reg_hit(ADDRESS, `IDX_ROUTE_DUTY)) begin
      rdata_nxt[7:0] = second_pair_route_and_duty_r;
    end else if (reg_hit(ADDRESS, `IDX_LS1_TIMING)) begin
      rdata_nxt[7:0] = lowswing_first_stage_timing_r;
    end else if (reg_hit(ADDRESS, `IDX_LS_PHASE)) begin
      rdata_nxt[7:0] = lowswing_phase_offsets_r;
    end else if (reg_hit(ADDRESS, `IDX_LS2_TIMING)) begin
      rdata_nxt[7:0] = lowswing_second_stage_timing_r;
    end else if (reg_hit(ADDRESS, `IDX_LS_CTRL)) begin
      rdata_nxt[7:0] = lowswing_bypass_and_sync_r;
    end else if (reg_hit(ADDRESS, `IDX_INPUT_SEL)) begin
      rdata_nxt[1:0] = input_sel_r;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= 32'h0000_0000;
    end else if (state_r == BUS_IDLE && READ) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign READDATA = rdata_r;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      second_pair_divider_timing_r <= `RST_DIV2_TIMING;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_DIV2_TIMING)) begin
      second_pair_divider_timing_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      second_pair_divider_control_r <= `RST_DIV2_CTRL;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_DIV2_CTRL)) begin
      second_pair_divider_control_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      second_pair_route_and_duty_r <= `RST_ROUTE_DUTY;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_ROUTE_DUTY)) begin
      second_pair_route_and_duty_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lowswing_first_stage_timing_r <= `RST_LS1_TIMING;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_LS1_TIMING)) begin
      lowswing_first_stage_timing_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lowswing_phase_offsets_r <= `RST_LS_PHASE;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_LS_PHASE)) begin
      lowswing_phase_offsets_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lowswing_second_stage_timing_r <= `RST_LS2_TIMING;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_LS2_TIMING)) begin
      lowswing_second_stage_timing_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lowswing_bypass_and_sync_r <= `RST_LS_CTRL;
    end else if (wr_en && reg_hit(ADDRESS, `IDX_LS_CTRL)) begin
      lowswing_bypass_and_sync_r <= WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      input_sel_r <= input_sel_t'(`RST_INPUT_SEL);
    end else if (wr_en && reg_hit(ADDRESS, `IDX_INPUT_SEL)) begin
      input_sel_r <= input_sel_t'(WRITEDATA[`INSEL_MSB:`INSEL_LSB]);
    end
  end

  // Divider input clock
  assign vco_s       = pins_s[0];
  assign ext_s       = pins_s[1];
  assign sync_active = ~pins_s[2];
  // Selector 01b and 11b keep the VCO feeding the dividers
  assign src_level   = (input_sel_r == SEL_EXT) ? ext_s : vco_s;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_level;
    end
  end

  assign src_rise = src_level & ~src_prev_r;

  // Second differential pair
  assign div2_nosync = second_pair_divider_control_r[`DIV2_NOSYNC_BIT];
  assign div2_hold   = sync_active & ~div2_nosync;
  assign div2_force  = sync_active & div2_nosync;
  // Odd periods cannot split evenly; correction gives the extra cycle to low
  assign div2_times  = second_pair_route_and_duty_r[`DUTY_DISABLE_BIT] ?
                       second_pair_divider_timing_r :
                       balance(second_pair_divider_timing_r[`LOW_MSB:`LOW_LSB],
                               second_pair_divider_timing_r[`HIGH_MSB:`HIGH_LSB]);

  chan_divider #(.CW (4)) u_div2 (
    .clk         (CLK),
    .rst_n       (RESET_N),
    .in_rise     (src_rise),
    .in_level    (src_level),
    .hold        (div2_hold),
    .bypass      (second_pair_divider_control_r[`DIV2_BYPASS_BIT]),
    .start_high  (second_pair_divider_control_r[`DIV2_START_BIT]),
    .low_cycles  (div2_times[`LOW_MSB:`LOW_LSB]),
    .high_cycles (div2_times[`HIGH_MSB:`HIGH_LSB]),
    .phase       (second_pair_divider_control_r[`DIV2_PHASE_MSB:`DIV2_PHASE_LSB]),
    .div_out     (div2_out)
  );

  always_comb begin
    pair_nxt = div2_force ? second_pair_divider_control_r[`DIV2_FORCE_BIT] : div2_out;
    if (second_pair_route_and_duty_r[`ROUTE_DIRECT_BIT]) begin
      if (input_sel_r == SEL_VCO) begin
        pair_nxt = vco_s;
      end else if (input_sel_r == SEL_EXT) begin
        pair_nxt = ext_s;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SECOND_PAIR_OUTPUT_A <= 1'b0;
      SECOND_PAIR_OUTPUT_B <= 1'b1;
    end else begin
      SECOND_PAIR_OUTPUT_A <= pair_nxt;
      SECOND_PAIR_OUTPUT_B <= ~pair_nxt;
    end
  end

  // Low-swing divider, two cascaded stages
  assign ls_nosync = lowswing_bypass_and_sync_r[`LS_NOSYNC_BIT];
  assign ls_hold   = sync_active & ~ls_nosync;
  assign ls_force  = sync_active & ls_nosync;

  chan_divider #(.CW (4)) u_ls1 (
    .clk         (CLK),
    .rst_n       (RESET_N),
    .in_rise     (src_rise),
    .in_level    (src_level),
    .hold        (ls_hold),
    .bypass      (lowswing_bypass_and_sync_r[`LS_BYPASS1_BIT]),
    .start_high  (lowswing_bypass_and_sync_r[`LS_START1_BIT]),
    .low_cycles  (lowswing_first_stage_timing_r[`LOW_MSB:`LOW_LSB]),
    .high_cycles (lowswing_first_stage_timing_r[`HIGH_MSB:`HIGH_LSB]),
    .phase       (lowswing_phase_offsets_r[`LS1_PHASE_MSB:`LS1_PHASE_LSB]),
    .div_out     (ls1_out)
  );

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ls1_prev_r <= 1'b0;
    end else begin
      ls1_prev_r <= ls1_out;
    end
  end

  assign ls1_rise = ls1_out & ~ls1_prev_r;

  chan_divider #(.CW (4)) u_ls2 (
    .clk         (CLK),
    .rst_n       (RESET_N),
    .in_rise     (ls1_rise),
    .in_level    (ls1_out),
    .hold        (ls_hold),
    .bypass      (lowswing_bypass_and_sync_r[`LS_BYPASS2_BIT]),
    .start_high  (lowswing_bypass_and_sync_r[`LS_START2_BIT]),
    .low_cycles  (lowswing_second_stage_timing_r[`LOW_MSB:`LOW_LSB]),
    .high_cycles (lowswing_second_stage_timing_r[`HIGH_MSB:`HIGH_LSB]),
    .phase       (lowswing_phase_offsets_r[`LS2_PHASE_MSB:`LS2_PHASE_LSB]),
    .div_out     (ls2_out)
  );

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LOWSWING_OUT <= 1'b0;
    end else begin
      LOWSWING_OUT <= ls_force ? lowswing_bypass_and_sync_r[`LS_FORCE_BIT] : ls2_out;
    end
  end

endmodule

/* hdl/sync_2ff.sv */
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* shared/clkdiv_defines.svh */
`ifndef CLKDIV_DEFINES_SVH
`define CLKDIV_DEFINES_SVH

// Register indexes; byte address is four times the index
`define IDX_DIV2_TIMING      10'h196
`define IDX_DIV2_CTRL        10'h197
`define IDX_ROUTE_DUTY       10'h198
`define IDX_LS1_TIMING       10'h199
`define IDX_LS_PHASE         10'h19A
`define IDX_LS2_TIMING       10'h19B
`define IDX_LS_CTRL          10'h19C
`define IDX_INPUT_SEL        10'h1E1

// Timing byte fields
`define LOW_MSB              7
`define LOW_LSB              4
`define HIGH_MSB             3
`define HIGH_LSB             0

// Second pair divider control
`define DIV2_BYPASS_BIT      7
`define DIV2_NOSYNC_BIT      6
`define DIV2_FORCE_BIT       5
`define DIV2_START_BIT       4
`define DIV2_PHASE_MSB       3
`define DIV2_PHASE_LSB       0

// Route and duty
`define ROUTE_DIRECT_BIT     1
`define DUTY_DISABLE_BIT     0

// Low-swing phase offsets
`define LS2_PHASE_MSB        7
`define LS2_PHASE_LSB        4
`define LS1_PHASE_MSB        3
`define LS1_PHASE_LSB        0

// Low-swing bypass and sync
`define LS_BYPASS2_BIT       5
`define LS_BYPASS1_BIT       4
`define LS_NOSYNC_BIT        3
`define LS_FORCE_BIT         2
`define LS_START2_BIT        1
`define LS_START1_BIT        0

// Input select
`define INSEL_MSB            1
`define INSEL_LSB            0

// Reset values
`define RST_DIV2_TIMING      8'h00
`define RST_DIV2_CTRL        8'h80
`define RST_ROUTE_DUTY       8'h00
`define RST_LS1_TIMING       8'h00
`define RST_LS_PHASE         8'h00
`define RST_LS2_TIMING       8'h00
`define RST_LS_CTRL          8'h00
`define RST_INPUT_SEL        2'h2

`endif

/* shared/clkdiv_pkg.sv */
package clkdiv_pkg;

  typedef logic [11:0] bus_addr_t;
  typedef logic [31:0] bus_word_t;
  typedef logic [7:0]  reg_byte_t;

  typedef enum logic [1:0] {
    SEL_EXT  = 2'b00,
    SEL_NONE = 2'b01,
    SEL_VCO  = 2'b10,
    SEL_RSVD = 2'b11
  } input_sel_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage
